// *** isgc_pkg.sv ***
// Shared constants and types for the slave control and general call block
package isgc_pkg;
   // Register port widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;

   // Register offsets (byte addresses)
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_STAT = 8'h04;
   localparam logic [7:0] OFF_ALT = 8'h08;
   localparam logic [7:0] OFF_OWN = 8'h0C;
   localparam logic [7:0] OFF_RXD = 8'h10;
   localparam logic [7:0] OFF_TXD = 8'h14;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h18;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h1C;

   // Control register bit positions
   localparam int CB_SLAVE_EN = 0;
   localparam int CB_ADDR10 = 1;
   localparam int CB_GC_EN = 2;
   localparam int CB_HWGC_EN = 3;
   localparam int CB_GC_CLR = 4;
   localparam int CB_EARLY_TX = 5;
   localparam int CB_FORCE_NACK = 7;
   // Bits that store a value; bit 4 is a strobe and bit 6 is reserved
   localparam logic [15:0] CTRL_STORE_MASK = 16'h00AF;

   // Status register bit positions
   localparam int SB_ADDRESSED = 0;
   localparam int SB_READ = 1;
   localparam int SB_GC_FLAG = 2;
   localparam int SB_GC_ID_LO = 3;
   localparam int SB_RX_VALID = 5;

   // General call identification codes held in the status register
   localparam logic [1:0] GC_ID_NONE = 2'h0;
   localparam logic [1:0] GC_ID_RESET = 2'h1;
   localparam logic [1:0] GC_ID_PROG = 2'h2;
   localparam logic [1:0] GC_ID_HW = 2'h3;

   // Bus byte values
   localparam logic [7:0] GC_ADDR = 8'h00;
   localparam logic [7:0] GC_CMD_RESET = 8'h06;
   localparam logic [7:0] GC_CMD_PROG = 8'h04;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   // Interrupt event bit positions
   localparam int EV_RX = 0;
   localparam int EV_TX_REQ = 1;
   localparam int EV_STOP = 2;
   localparam int EV_GC = 3;
   localparam int EV_W = 4;

   // Byte engine states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_ACK = 3'b010,
      ST_RX = 3'b011,
      ST_TX = 3'b100,
      ST_TXACK = 3'b101
   } isgc_state_t;
endpackage : isgc_pkg

// *** isgc_pin_sync.sv ***
// Two-stage synchronisers and edge / start / stop detection for the bus pins
`timescale 1ns/1ps
module isgc_pin_sync (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Raw pins
   input wire logic scl_pin,
   input wire logic sda_pin,
   // Synchronised level and events
   output logic sda_level,
   output logic scl_rise,
   output logic scl_fall,
   output logic start_det,
   output logic stop_det
);
   typedef struct packed {
      logic [1:0] scl_meta;
      logic [1:0] sda_meta;
      logic scl_last;
      logic sda_last;
   } isgc_sync_t;

   isgc_sync_t sync_reg;
   isgc_sync_t sync_next;

   // Bit 0 is the first stage and feeds only bit 1
   always_comb begin
      sync_next = sync_reg;
      sync_next.scl_meta = {sync_reg.scl_meta[0], scl_pin};
      sync_next.sda_meta = {sync_reg.sda_meta[0], sda_pin};
      sync_next.scl_last = sync_reg.scl_meta[1];
      sync_next.sda_last = sync_reg.sda_meta[1];
   end

   // Idle bus is high, so reset to high to avoid a false edge
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sync_reg <= '1;
      end else begin
         sync_reg <= sync_next;
      end
   end

   // Events look only at the second and third stages
   assign sda_level = sync_reg.sda_meta[1];
   assign scl_rise = sync_reg.scl_meta[1] & ~sync_reg.scl_last;
   assign scl_fall = ~sync_reg.scl_meta[1] & sync_reg.scl_last;
   assign start_det = sync_reg.scl_meta[1] & sync_reg.scl_last & sync_reg.sda_last
      & ~sync_reg.sda_meta[1];
   assign stop_det = sync_reg.scl_meta[1] & sync_reg.scl_last & ~sync_reg.sda_last
      & sync_reg.sda_meta[1];
endmodule : isgc_pin_sync

// *** isgc_slave.sv ***
// Serial bus slave with acknowledge control, transmit request timing and general call
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ps
// What this block does
// - force_nack_next set: next byte gets not-acknowledge
// - force_nack_next clear: hardware decides acknowledge
// - early_tx_irq_sel set: request after clock rise
// - early_tx_irq_sel clear: request after clock fall
// - writing one clears general call flag, ID
// - both enables: compare byte after address zero
// - hardware call only when byte equals alternate
// - hw_gencall_enable clear: no hardware general call
// - gencall_enable: acknowledge zero, 0x06 resets, 0x04 flags
// - slave works only while slave_enable set
module isgc_slave (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Register port
   input wire logic [isgc_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [isgc_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [isgc_pkg::DATA_W-1:0] reg_rdata,
   // Interrupt
   output logic irq,
   // Bus pins, open drain data
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe
);
   typedef struct packed {
      isgc_pkg::isgc_state_t st;
      logic [3:0] bitcnt;
      logic [7:0] shift;
      logic sda_drive;
      logic ack_given;
      logic rw;
      logic gc_phase;
      logic addressed;
      logic [15:0] ctrl;
      logic [7:0] alt_addr;
      logic [6:0] own_addr;
      logic [7:0] rx_data;
      logic rx_valid;
      logic [7:0] tx_data;
      logic gc_flag;
      logic [1:0] gc_id;
      logic [isgc_pkg::EV_W-1:0] ev_stat;
      logic [isgc_pkg::EV_W-1:0] ev_mask;
      logic [15:0] rdata;
   } isgc_core_t;

   isgc_core_t core_reg;
   isgc_core_t core_next;

   logic sda_level;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;

   // Address decode, used for both reads and writes
   function automatic logic hit(input logic [isgc_pkg::ADDR_W-1:0] addr,
                                input logic [7:0] off);
      hit = (addr == off);
   endfunction : hit

   // Pin synchronisers and bus condition detection
   isgc_pin_sync u_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .scl_pin(scl_in),
      .sda_pin(sda_in),
      .sda_level(sda_level),
      .scl_rise(scl_rise),
      .scl_fall(scl_fall),
      .start_det(start_det),
      .stop_det(stop_det)
   );

   // Register access and byte engine in one next-state process
   always_comb begin
      logic [isgc_pkg::EV_W-1:0] ev_set;
      logic [7:0] byte_in;
      logic en;
      logic gc_on;
      logic hw_on;
      logic nack_forced;
      logic early;
      logic addr_match;
      ev_set = '0;
      byte_in = {core_reg.shift[6:0], sda_level};
      core_next = core_reg;
      en = core_reg.ctrl[isgc_pkg::CB_SLAVE_EN];
      gc_on = core_reg.ctrl[isgc_pkg::CB_GC_EN];
      hw_on = gc_on & core_reg.ctrl[isgc_pkg::CB_HWGC_EN];
      nack_forced = core_reg.ctrl[isgc_pkg::CB_FORCE_NACK];
      early = core_reg.ctrl[isgc_pkg::CB_EARLY_TX];
      addr_match = (core_reg.shift[7:1] == core_reg.own_addr);
      core_next.rdata = 16'h0000;

      // Byte engine
      unique case (core_reg.st)
         isgc_pkg::ST_IDLE: begin
            core_next.sda_drive = 1'h0;
         end
         isgc_pkg::ST_ADDR: begin
            if (scl_rise) begin
               core_next.shift = byte_in;
               core_next.bitcnt = core_reg.bitcnt + 4'h1;
               // Read bit of a matching address, early request timing
               if (core_reg.bitcnt == isgc_pkg::BITS_PER_BYTE - 4'h1 && sda_level
                   && byte_in[7:1] == core_reg.own_addr && early && !nack_forced) begin
                  ev_set[isgc_pkg::EV_TX_REQ] = 1'h1;
               end
            end else if (scl_fall && core_reg.bitcnt == isgc_pkg::BITS_PER_BYTE) begin
               core_next.bitcnt = 4'h0;
               core_next.rw = core_reg.shift[0];
               core_next.gc_phase = 1'h0;
               core_next.ack_given = 1'h0;
               core_next.st = isgc_pkg::ST_ACK;
               if (nack_forced) begin
                  core_next.ack_given = 1'h0;
               end else if (addr_match) begin
                  core_next.ack_given = 1'h1;
                  core_next.addressed = 1'h1;
                  if (core_reg.shift[0] && !early) begin
                     ev_set[isgc_pkg::EV_TX_REQ] = 1'h1;
                  end
               end else if (core_reg.shift == isgc_pkg::GC_ADDR && gc_on) begin
                  core_next.ack_given = 1'h1;
                  core_next.gc_phase = 1'h1;
                  core_next.addressed = 1'h1;
               end
               core_next.sda_drive = core_next.ack_given;
            end
         end
         isgc_pkg::ST_ACK: begin
            // Acknowledge bit lasts until the next falling clock edge
            if (scl_fall) begin
               if (!core_reg.ack_given) begin
                  core_next.sda_drive = 1'h0;
                  core_next.addressed = 1'h0;
                  core_next.st = isgc_pkg::ST_IDLE;
               end else if (core_reg.rw) begin
                  core_next.shift = core_reg.tx_data;
                  core_next.sda_drive = ~core_reg.tx_data[7];
                  core_next.bitcnt = 4'h1;
                  core_next.st = isgc_pkg::ST_TX;
               end else begin
                  core_next.sda_drive = 1'h0;
                  core_next.st = isgc_pkg::ST_RX;
               end
            end
         end
         isgc_pkg::ST_RX: begin
            if (scl_rise) begin
               core_next.shift = byte_in;
               core_next.bitcnt = core_reg.bitcnt + 4'h1;
            end else if (scl_fall && core_reg.bitcnt == isgc_pkg::BITS_PER_BYTE) begin
               core_next.bitcnt = 4'h0;
               core_next.ack_given = ~nack_forced;
               core_next.sda_drive = ~nack_forced;
               core_next.rw = 1'h0;
               core_next.st = isgc_pkg::ST_ACK;
               if (!core_reg.gc_phase) begin
                  core_next.rx_data = core_reg.shift;
                  core_next.rx_valid = 1'h1;
                  ev_set[isgc_pkg::EV_RX] = 1'h1;
               end else begin
                  // First data byte after the general call address
                  core_next.gc_phase = 1'h0;
                  if (hw_on && core_reg.shift == core_reg.alt_addr) begin
                     core_next.gc_flag = 1'h1;
                     core_next.gc_id = isgc_pkg::GC_ID_HW;
                     ev_set[isgc_pkg::EV_GC] = 1'h1;
                  end else if (core_reg.shift == isgc_pkg::GC_CMD_RESET) begin
                     // Reset the interface as the acknowledge bit starts
                     core_next.gc_flag = 1'h1;
                     core_next.gc_id = isgc_pkg::GC_ID_RESET;
                     core_next.rx_valid = 1'h0;
                     core_next.tx_data = 8'h00;
                     core_next.rw = 1'h0;
                     ev_set[isgc_pkg::EV_GC] = 1'h1;
                  end else if (core_reg.shift == isgc_pkg::GC_CMD_PROG) begin
                     core_next.gc_flag = 1'h1;
                     core_next.gc_id = isgc_pkg::GC_ID_PROG;
                     ev_set[isgc_pkg::EV_GC] = 1'h1;
                  end else begin
                     // Unknown command, or hw call not matched: pass on as data
                     core_next.rx_data = core_reg.shift;
                     core_next.rx_valid = 1'h1;
                     ev_set[isgc_pkg::EV_RX] = 1'h1;
                  end
               end
            end
         end
         isgc_pkg::ST_TX: begin
            // Bits change on the falling edge, master samples on the rise
            if (scl_fall) begin
               if (core_reg.bitcnt == isgc_pkg::BITS_PER_BYTE) begin
                  core_next.sda_drive = 1'h0;
                  core_next.st = isgc_pkg::ST_TXACK;
               end else begin
                  core_next.shift = {core_reg.shift[6:0], 1'h0};
                  core_next.sda_drive = ~core_reg.shift[6];
                  core_next.bitcnt = core_reg.bitcnt + 4'h1;
               end
            end
         end
         isgc_pkg::ST_TXACK: begin
            if (scl_rise) begin
               core_next.ack_given = ~sda_level;
               if (!sda_level && early) begin
                  ev_set[isgc_pkg::EV_TX_REQ] = 1'h1;
               end
            end else if (scl_fall) begin
               if (core_reg.ack_given) begin
                  // Master wants another byte
                  if (!early) begin
                     ev_set[isgc_pkg::EV_TX_REQ] = 1'h1;
                  end
                  core_next.shift = core_reg.tx_data;
                  core_next.sda_drive = ~core_reg.tx_data[7];
                  core_next.bitcnt = 4'h1;
                  core_next.st = isgc_pkg::ST_TX;
               end else begin
                  core_next.addressed = 1'h0;
                  core_next.st = isgc_pkg::ST_IDLE;
               end
            end
         end
         default: begin
            core_next.st = isgc_pkg::ST_IDLE;
         end
      endcase

      // Bus conditions take priority over the bit engine
      if (start_det) begin
         core_next.st = isgc_pkg::ST_ADDR;
         core_next.bitcnt = 4'h0;
         core_next.sda_drive = 1'h0;
         core_next.gc_phase = 1'h0;
      end else if (stop_det) begin
         core_next.st = isgc_pkg::ST_IDLE;
         core_next.sda_drive = 1'h0;
         if (core_reg.addressed) begin
            ev_set[isgc_pkg::EV_STOP] = 1'h1;
         end
         core_next.addressed = 1'h0;
      end

      // Disabled slave releases the bus and ignores it
      if (!en) begin
         core_next.st = isgc_pkg::ST_IDLE;
         core_next.sda_drive = 1'h0;
         core_next.addressed = 1'h0;
         core_next.gc_phase = 1'h0;
         ev_set = '0;
      end

      // Register reads; data stand in the following cycle only
      if (reg_rd) begin
         if (hit(reg_addr, isgc_pkg::OFF_CTRL)) begin
            core_next.rdata = core_reg.ctrl;
         end else if (hit(reg_addr, isgc_pkg::OFF_STAT)) begin
            core_next.rdata[isgc_pkg::SB_ADDRESSED] = core_reg.addressed;
            core_next.rdata[isgc_pkg::SB_READ] = core_reg.rw;
            core_next.rdata[isgc_pkg::SB_GC_FLAG] = core_reg.gc_flag;
            core_next.rdata[isgc_pkg::SB_GC_ID_LO +: 2] = core_reg.gc_id;
            core_next.rdata[isgc_pkg::SB_RX_VALID] = core_reg.rx_valid;
         end else if (hit(reg_addr, isgc_pkg::OFF_ALT)) begin
            core_next.rdata = {8'h00, core_reg.alt_addr};
         end else if (hit(reg_addr, isgc_pkg::OFF_OWN)) begin
            core_next.rdata = {9'h000, core_reg.own_addr};
         end else if (hit(reg_addr, isgc_pkg::OFF_RXD)) begin
            core_next.rdata = {8'h00, core_reg.rx_data};
            // A byte landing in the read cycle keeps its valid flag
            core_next.rx_valid = ev_set[isgc_pkg::EV_RX];
         end else if (hit(reg_addr, isgc_pkg::OFF_TXD)) begin
            core_next.rdata = {8'h00, core_reg.tx_data};
         end else if (hit(reg_addr, isgc_pkg::OFF_IRQ_STAT)) begin
            core_next.rdata = {12'h000, core_reg.ev_stat};
            core_next.ev_stat = '0;
         end else if (hit(reg_addr, isgc_pkg::OFF_IRQ_MASK)) begin
            core_next.rdata = {12'h000, core_reg.ev_mask};
         end
      end

      // Register writes; reserved control bit six never stored
      if (reg_wr) begin
         if (hit(reg_addr, isgc_pkg::OFF_CTRL)) begin
            core_next.ctrl = reg_wdata & isgc_pkg::CTRL_STORE_MASK;
            // A call landing in the same cycle keeps its flag and ID: set wins
            if (reg_wdata[isgc_pkg::CB_GC_CLR] && !ev_set[isgc_pkg::EV_GC]) begin
               core_next.gc_flag = 1'h0;
               core_next.gc_id = isgc_pkg::GC_ID_NONE;
            end
         end else if (hit(reg_addr, isgc_pkg::OFF_ALT)) begin
            core_next.alt_addr = reg_wdata[7:0];
         end else if (hit(reg_addr, isgc_pkg::OFF_OWN)) begin
            core_next.own_addr = reg_wdata[6:0];
         end else if (hit(reg_addr, isgc_pkg::OFF_TXD)) begin
            core_next.tx_data = reg_wdata[7:0];
         end else if (hit(reg_addr, isgc_pkg::OFF_IRQ_MASK)) begin
            core_next.ev_mask = reg_wdata[isgc_pkg::EV_W-1:0];
         end
      end

      // New events win over a read clear in the same cycle
      core_next.ev_stat = core_next.ev_stat | ev_set;
   end

   // State register; all control state starts cleared
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         core_reg <= '0;
      end else begin
         core_reg <= core_next;
      end
   end

   // Outputs
   assign reg_rdata = core_reg.rdata;
   assign irq = |(core_reg.ev_stat & core_reg.ev_mask);
   assign sda_out = 1'h0; // Open drain: only ever pulls low
   assign sda_oe = core_reg.sda_drive;
endmodule : isgc_slave

// *** isgc_master_model.sv ***
// Bus master model: drives the bus clock and pulls the open-drain data line
`timescale 1ns/1ps
module isgc_master_model (
   // Resolved data level
   input wire logic sda,
   // Driven lines
   output logic scl,
   output logic sda_pull
);
   // Idle bus: clock stands high, data left to the pull-up
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   // Start: data falls while the clock is high
   task automatic start();
      #100 sda_pull = 1'b1;
      #100 scl = 1'b0;
   endtask : start
   // One 200 ns bit; data moves mid low phase, sampled late in the high phase
   task automatic clk_bit(input logic b, output logic s);
      #60 sda_pull = ~b;
      #60 scl = 1'b1;
      #70 s = sda;
      #10 scl = 1'b0;
   endtask : clk_bit
   // Byte out, MSB first, then the acknowledge bit is read back
   task automatic send_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(d[i], s);
      end
      clk_bit(1'b1, ack);
   endtask : send_byte
   // Byte in, then our own acknowledge (1 = not acknowledged)
   task automatic recv_byte(input logic nack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(1'b1, s);
         d[i] = s;
      end
      clk_bit(nack, s);
   endtask : recv_byte
   // Stop: data rises while the clock is high
   task automatic stop();
      #60 sda_pull = 1'b1;
      #60 scl = 1'b1;
      #100 sda_pull = 1'b0;
      #100;
   endtask : stop
endmodule : isgc_master_model

// *** isgc_slave_monitor.sv ***
// Concurrent checks on the ports of the slave block
`timescale 1ns/1ps
module isgc_slave_monitor (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Register port
   input wire logic [isgc_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [isgc_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [isgc_pkg::DATA_W-1:0] reg_rdata,
   // Interrupt and bus pins
   input wire logic irq,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe
);
   typedef struct packed {
      logic [15:0] ctrl;
      logic [isgc_pkg::EV_W-1:0] mask;
      logic en_d;
      logic nack_d;
   } isgc_shadow_t;
   isgc_shadow_t sh_reg;
   isgc_shadow_t sh_next;
   // Shadow of software state; delayed copies cover the write latency
   always_comb begin
      sh_next = sh_reg;
      sh_next.en_d = sh_reg.ctrl[isgc_pkg::CB_SLAVE_EN];
      sh_next.nack_d = sh_reg.ctrl[isgc_pkg::CB_FORCE_NACK];
      if (reg_wr && reg_addr == isgc_pkg::OFF_CTRL) begin
         sh_next.ctrl = reg_wdata & isgc_pkg::CTRL_STORE_MASK;
      end
      if (reg_wr && reg_addr == isgc_pkg::OFF_IRQ_MASK) begin
         sh_next.mask = reg_wdata[isgc_pkg::EV_W-1:0];
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sh_reg <= '0;
      end else begin
         sh_reg <= sh_next;
      end
   end
   default clocking mon_cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   AST_CTRL_READ: assert property ($past(reg_rd) && $past(reg_addr) == isgc_pkg::OFF_CTRL
      |-> reg_rdata == sh_reg.ctrl) else $error("control read differs from stored bits");
   AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == '0)
      else $error("read data not zero outside answer cycle");
   AST_GC_CLEAR: assert property (reg_wr && reg_addr == isgc_pkg::OFF_CTRL
      && reg_wdata[isgc_pkg::CB_GC_CLR] ##2 reg_rd && reg_addr == isgc_pkg::OFF_STAT
      |=> reg_rdata[4:2] == 3'h0) else $error("general call flag or id survived clear");
   AST_DISABLED_QUIET: assert property (!sh_reg.ctrl[0] && !sh_reg.en_d |-> !sda_oe)
      else $error("data driven while slave disabled");
   AST_FORCE_NACK: assert property (sh_reg.ctrl[7] && sh_reg.nack_d |-> !sda_oe)
      else $error("data driven while forced not-acknowledge set");
   AST_OE_SCL_LOW: assert property ($changed(sda_oe) |-> !$past(scl_in, 2))
      else $error("data drive changed with bus clock high");
   AST_OE_PULLS_LOW: assert property (sda_oe |-> sda_out == 1'b0)
      else $error("enabled data output not low");
   AST_IRQ_MASKED: assert property (sh_reg.mask == '0 |-> !irq)
      else $error("interrupt with all events masked");
   AST_IRQ_CAUSE: assert property (irq && reg_rd && reg_addr == isgc_pkg::OFF_IRQ_STAT
      |=> (reg_rdata[isgc_pkg::EV_W-1:0] & sh_reg.mask) != '0)
      else $error("interrupt without a pending unmasked event");
endmodule : isgc_slave_monitor

bind isgc_slave isgc_slave_monitor mon_u (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
   .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe));

// *** tb_isgc_slave.sv ***
// Self-checking bench for the slave control and general call block
`timescale 1ns/1ps
module tb_isgc_slave;
   logic clk;
   logic sys_rst;
   logic [7:0] reg_addr;
   logic [15:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [15:0] reg_rdata;
   logic irq;
   logic scl;
   logic sda_out;
   logic sda_oe;
   logic m_pull;
   wire logic sda;
   int bad_count;
   int checked;
   logic rd_d;
   logic [31:0] note;
   logic [31:0] exp_q[$];
   logic [7:0] own, alt, dat, rx;
   logic ack, e1, e2;
   logic [15:0] gc_ctl[6];
   logic [7:0] gc_dat[6];
   logic [15:0] gc_st[6];
   // Open drain with pull-up: low if either party pulls
   assign sda = (sda_oe ? sda_out : 1'b1) & ~m_pull;
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   isgc_slave dut_u (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .scl_in(scl),
      .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe));
   isgc_master_model mst_u (.sda(sda), .scl(scl), .sda_pull(m_pull));
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   // Read: the expected value and its care mask are noted for the watcher
   task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      exp_q.push_back({m, e & m});
      @(posedge clk);
      reg_rd <= 1'b0;
   endtask : rd
   // Watcher: read data stand one cycle only, so they are taken mid-cycle
   always @(posedge clk) rd_d <= reg_rd;
   always @(negedge clk) begin
      if (rd_d === 1'b1 && exp_q.size() > 0) begin
         note = exp_q.pop_front();
         chk("reg_rdata", note[15:0], reg_rdata & note[31:16]);
      end
   end
   task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic ea);
      mst_u.start();
      mst_u.send_byte(a, ack);
      chk("address ack", {15'h0, ea}, {15'h0, ack});
      if (ack === 1'b0) begin
         mst_u.send_byte(d, ack);
         chk("data ack", 16'h0000, {15'h0, ack});
      end
      mst_u.stop();
   endtask : xfer
   task automatic end_sim();
      $display("Checks %0d, mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : end_sim
   // Hang guard
   initial begin
      #2000000;
      bad_count++;
      end_sim();
   end
   initial begin
      sys_rst = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      void'($urandom(32'hEF1C));
      own = 8'($urandom_range(119, 8));
      alt = 8'($urandom) | 8'h01;
      dat = 8'($urandom);
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (3) @(posedge clk);
      // Reset values, unmapped place, strobe bit four and upper byte ignored
      rd(isgc_pkg::OFF_CTRL, 16'h0000, 16'hFFFF);
      wr(8'h20, 16'hFFFF);
      rd(8'h20, 16'h0000, 16'hFFFF);
      wr(isgc_pkg::OFF_CTRL, 16'hFFBF);
      rd(isgc_pkg::OFF_CTRL, isgc_pkg::CTRL_STORE_MASK, 16'hFFFF);
      wr(isgc_pkg::OFF_CTRL, 16'h0000);
      wr(isgc_pkg::OFF_OWN, {8'h00, own});
      wr(isgc_pkg::OFF_ALT, {8'h00, alt});
      $display("registers done");
      xfer({own[6:0], 1'b0}, dat, 1'b1);
      wr(isgc_pkg::OFF_CTRL, 16'h0001);
      xfer({own[6:0], 1'b0}, dat, 1'b0);
      chk("irq masked", 16'h0000, {15'h0, irq});
      rd(isgc_pkg::OFF_RXD, {8'h00, dat}, 16'h00FF);
      rd(isgc_pkg::OFF_IRQ_STAT, 16'h0005, 16'h000F);
      rd(isgc_pkg::OFF_IRQ_STAT, 16'h0000, 16'h000F);
      wr(isgc_pkg::OFF_CTRL, 16'h0081);
      xfer({own[6:0], 1'b0}, dat, 1'b1);
      $display("acknowledge done");
      wr(isgc_pkg::OFF_TXD, {8'h00, dat});
      wr(isgc_pkg::OFF_IRQ_MASK, 16'h0002);
      // Transmit request against the eighth clock fall, early and late
      for (int e = 1; e >= 0; e--) begin
         wr(isgc_pkg::OFF_CTRL, 16'h0001 | 16'(e << 5));
         fork
            begin
               mst_u.start();
               mst_u.send_byte({own[6:0], 1'b1}, ack);
               mst_u.recv_byte(1'b1, rx);
               mst_u.stop();
            end
            begin
               repeat (8) @(posedge scl);
               @(negedge scl);
               #40 e1 = irq;
               #110 e2 = irq;
            end
         join
         chk("irq at fall", 16'(e), {15'h0, e1});
         chk("irq after fall", 16'h0001, {15'h0, e2});
         chk("read byte", {8'h00, dat}, {8'h00, rx});
         rd(isgc_pkg::OFF_IRQ_STAT, 16'h0002, 16'h0002);
         @(negedge clk);
         chk("irq cleared", 16'h0000, {15'h0, irq});
      end
      $display("transmit request done");
      gc_ctl = '{16'h0005, 16'h0005, 16'h000D, 16'h0005, 16'h000D, 16'h0001};
      gc_dat = '{8'h04, 8'h06, alt, alt, alt ^ 8'h02, 8'h04};
      gc_st = '{16'h0014, 16'h000C, 16'h001C, 16'h0000, 16'h0000, 16'h0000};
      wr(isgc_pkg::OFF_IRQ_MASK, 16'h0008);
      for (int i = 0; i < 6; i++) begin
         wr(isgc_pkg::OFF_CTRL, gc_ctl[i]);
         xfer(isgc_pkg::GC_ADDR, gc_dat[i], i == 5);
         chk("irq", {15'h0, gc_st[i] != 0}, {15'h0, irq});
         rd(isgc_pkg::OFF_STAT, gc_st[i], 16'h001C);
         rd(isgc_pkg::OFF_IRQ_STAT, {gc_st[i] != 0, 3'h0}, 16'h0008);
         wr(isgc_pkg::OFF_CTRL, gc_ctl[i] | 16'h0010);
         rd(isgc_pkg::OFF_STAT, 16'h0000, 16'h001C);
         chk("irq cleared", 16'h0000, {15'h0, irq});
      end
      // The 0x06 call above must have wiped the transmit byte
      rd(isgc_pkg::OFF_TXD, 16'h0000, 16'h00FF);
      $display("general call done");
      repeat (3) @(posedge clk);
      end_sim();
   end
endmodule : tb_isgc_slave
